// >>> shared/dccr_defs.svh
`ifndef DCCR_DEFS_SVH
`define DCCR_DEFS_SVH
// register offsets (byte addresses of the control port)
`define DCCR_ADDR_FMT 7'h41
`define DCCR_ADDR_OPF 7'h42
`define DCCR_ADDR_INV 7'h43
`define DCCR_ADDR_MUTE 7'h44
`define DCCR_ADDR_ATT_BASE 7'h48
`define DCCR_ADDR_ATT_LAST 7'h4f
// reset values
`define DCCR_RST_FMT 8'h00
`define DCCR_RST_OPF 8'h00
`define DCCR_RST_INV 8'h00
`define DCCR_RST_MUTE 8'h00
`define DCCR_RST_ATT 8'hff
// field positions
`define DCCR_PSM_BIT 7
`define DCCR_FMT_MSB 3
`define DCCR_FMT_LSB 0
`define DCCR_DIS_MSB 7
`define DCCR_DIS_LSB 4
`define DCCR_FLT_MSB 3
`define DCCR_FLT_LSB 0
// attenuator codes
`define DCCR_ATT_MUTE 8'h00
// ramp period: one step per this many sample periods
`define DCCR_RAMP_SAMPLES 4'h8
`define DCCR_RAMP_CNT_LAST 3'h7
`endif

// >>> shared/dccr_pkg.sv
package dccr_pkg;
  typedef enum logic [3:0] {
    DCCR_FMT_I2S = 4'h0,
    DCCR_FMT_LJ = 4'h1,
    DCCR_FMT_RJ24 = 4'h2,
    DCCR_FMT_RJ16 = 4'h3,
    DCCR_FMT_DSP_I2S = 4'h4,
    DCCR_FMT_DSP_LJ = 4'h5,
    DCCR_FMT_TDM_I2S = 4'h6,
    DCCR_FMT_TDM_LJ = 4'h7,
    DCCR_FMT_HTDM_I2S = 4'h8,
    DCCR_FMT_HTDM_LJ = 4'h9
  } dccr_fmt_t;

  // decoded framing handed to the serial audio receiver
  typedef struct packed {
    logic i2s_align;
    logic rj_mode;
    logic rj_16bit;
    logic dsp_mode;
    logic tdm_mode;
    logic tdm_high_speed;
    logic fmt_invalid;
  } dccr_frame_t;

  // per-pair analog/data-path controls
  typedef struct packed {
    logic [3:0] data_disconnect;
    logic [3:0] path_clear;
    logic [3:0] hold_common_mode;
    logic [3:0] drive_analog_ground;
    logic [3:0] power_down;
    logic [3:0] rolloff_slow;
  } dccr_pair_ctl_t;
endpackage

// >>> src/dccr_regs.sv
// Function
// - power-save policy 0 makes pair disable a power-save; 1 a plain disable.
// - format code 0000 (reset) selects I2S, 0001 selects left-justified.
// - code 0010 selects 24-bit right-justified, 0011 16-bit right-justified.
// - code 0100 DSP with I2S alignment, 0101 DSP left-justified.
// - code 0110 TDM with I2S alignment, 0111 TDM left-justified.
// - codes 1000 and 1001 select high-speed TDM, I2S then left-justified.
// - four disable bits, one per channel pair, reset to normal operation.
// - disabled pair is cut from audio input and its data path cleared.
// - disabled pair with policy 1 holds outputs at common-mode level.
// - disabled pair with policy 0 drives analog ground and powers down.
// - host keeps disable bits zero normally; control port always stays live.
// - four roll-off bits, one per pair, 0 sharp, 1 slow, reset 0000.
// - setting mute ramps attenuator stepwise down to infinite attenuation.
// - clearing mute ramps attenuator back up to programmed level.
// - soft mute reuses the attenuator and overrides the programmed level.
// - attenuator ramps move one step per eight sample periods; a disabled pair jumps straight to its target.
`timescale 1ns/100ps
`include "dccr_defs.svh"
module dccr_regs #(
  parameter int NCH = 8,
  parameter int NPAIR = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sample_tick,
  output dccr_pkg::dccr_fmt_t interface_format_sel,
  output dccr_pkg::dccr_frame_t frame_cfg,
  output logic power_save_policy,
  output dccr_pkg::dccr_pair_ctl_t pair_ctl,
  output logic [NCH-1:0] output_invert,
  output logic [NCH*8-1:0] atten_level,
  output logic [NCH-1:0] ramp_busy
);
  import dccr_pkg::*;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] fmt_q;
  logic [7:0] opf_q;
  logic [7:0] inv_q;
  logic [7:0] mute_q;
  logic [7:0] att_prog_q [NCH];
  logic [7:0] att_cur_q [NCH];
  logic [7:0] rdata_q;
  logic [3:0] pair_disable;
  logic [3:0] rolloff_select;
  logic [NCH-1:0] soft_mute_en;

  function automatic logic is_att_addr(input logic [6:0] a);
    return a >= `DCCR_ADDR_ATT_BASE && a <= `DCCR_ADDR_ATT_LAST;
  endfunction

  function automatic logic [2:0] att_idx(input logic [6:0] a);
    logic [6:0] d;
    d = a - `DCCR_ADDR_ATT_BASE;
    return d[2:0];
  endfunction

  // reserved bits 6:4 are stored as written; host keeps them zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fmt_q <= `DCCR_RST_FMT;
      opf_q <= `DCCR_RST_OPF;
      inv_q <= `DCCR_RST_INV;
      mute_q <= `DCCR_RST_MUTE;
    end else if (reg_wr) begin
      // writes are taken whatever the pair state
      case (reg_addr)
        `DCCR_ADDR_FMT: fmt_q <= reg_wdata;
        `DCCR_ADDR_OPF: opf_q <= reg_wdata;
        `DCCR_ADDR_INV: inv_q <= reg_wdata;
        `DCCR_ADDR_MUTE: mute_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        att_prog_q[i] <= `DCCR_RST_ATT;
      end
    end else if (reg_wr && is_att_addr(reg_addr)) begin
      att_prog_q[att_idx(reg_addr)] <= reg_wdata;
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      if (is_att_addr(reg_addr)) begin
        rdata_q <= att_prog_q[att_idx(reg_addr)];
      end else begin
        case (reg_addr)
          `DCCR_ADDR_FMT: rdata_q <= fmt_q;
          `DCCR_ADDR_OPF: rdata_q <= opf_q;
          `DCCR_ADDR_INV: rdata_q <= inv_q;
          `DCCR_ADDR_MUTE: rdata_q <= mute_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // format decode
  // ---------------------------------------------------------------
  assign power_save_policy = fmt_q[`DCCR_PSM_BIT];
  assign interface_format_sel =
    dccr_fmt_t'(fmt_q[`DCCR_FMT_MSB:`DCCR_FMT_LSB]);

  // reserved codes are flagged only; behaviour then is undefined
  always_comb begin
    frame_cfg = '0;
    case (fmt_q[`DCCR_FMT_MSB:`DCCR_FMT_LSB])
      DCCR_FMT_I2S: frame_cfg.i2s_align = 1'b1;
      DCCR_FMT_LJ: frame_cfg.i2s_align = 1'b0;
      DCCR_FMT_RJ24: frame_cfg.rj_mode = 1'b1;
      DCCR_FMT_RJ16: begin
        frame_cfg.rj_mode = 1'b1;
        frame_cfg.rj_16bit = 1'b1;
      end
      DCCR_FMT_DSP_I2S: begin
        frame_cfg.dsp_mode = 1'b1;
        frame_cfg.i2s_align = 1'b1;
      end
      DCCR_FMT_DSP_LJ: frame_cfg.dsp_mode = 1'b1;
      DCCR_FMT_TDM_I2S: begin
        frame_cfg.tdm_mode = 1'b1;
        frame_cfg.i2s_align = 1'b1;
      end
      DCCR_FMT_TDM_LJ: frame_cfg.tdm_mode = 1'b1;
      DCCR_FMT_HTDM_I2S: begin
        frame_cfg.tdm_mode = 1'b1;
        frame_cfg.tdm_high_speed = 1'b1;
        frame_cfg.i2s_align = 1'b1;
      end
      DCCR_FMT_HTDM_LJ: begin
        frame_cfg.tdm_mode = 1'b1;
        frame_cfg.tdm_high_speed = 1'b1;
      end
      default: frame_cfg.fmt_invalid = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------
  // pair controls
  // ---------------------------------------------------------------
  assign pair_disable = opf_q[`DCCR_DIS_MSB:`DCCR_DIS_LSB];
  assign rolloff_select = opf_q[`DCCR_FLT_MSB:`DCCR_FLT_LSB];

  always_comb begin
    pair_ctl.data_disconnect = pair_disable;
    pair_ctl.path_clear = pair_disable;
    pair_ctl.hold_common_mode =
      pair_disable & {NPAIR{power_save_policy}};
    pair_ctl.drive_analog_ground =
      pair_disable & {NPAIR{~power_save_policy}};
    pair_ctl.power_down =
      pair_disable & {NPAIR{~power_save_policy}};
    pair_ctl.rolloff_slow = rolloff_select;
  end

  assign output_invert = inv_q;
  assign soft_mute_en = mute_q;

  // ---------------------------------------------------------------
  // attenuator ramps
  // ---------------------------------------------------------------
  // one shared sample counter keeps all channels stepping in lockstep
  logic [2:0] smp_cnt_q;
  logic step_ok;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      smp_cnt_q <= 3'h0;
    end else if (sample_tick) begin
      smp_cnt_q <= smp_cnt_q + 3'h1;
    end
  end
  assign step_ok = sample_tick && smp_cnt_q == `DCCR_RAMP_CNT_LAST;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [7:0] target;
      // mute overrides the programmed level
      assign target = soft_mute_en[g] ? `DCCR_ATT_MUTE : att_prog_q[g];
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          att_cur_q[g] <= `DCCR_RST_ATT;
        end else if (pair_disable[g/2]) begin
          att_cur_q[g] <= target;
        end else if (step_ok) begin
          if (att_cur_q[g] > target) begin
            att_cur_q[g] <= att_cur_q[g] - 8'h01;
          end else if (att_cur_q[g] < target) begin
            att_cur_q[g] <= att_cur_q[g] + 8'h01;
          end
        end
      end
      assign atten_level[g*8 +: 8] = att_cur_q[g];
      assign ramp_busy[g] = att_cur_q[g] != target;
    end
  endgenerate
endmodule // dccr_regs

// >>> tb/dccr_regs_asserts.sv
`timescale 1ns/100ps
module dccr_regs_asserts import dccr_pkg::*; #(
  parameter int NCH = 8
) (
  input logic sys_clk,
  input logic resetn,
  input logic [6:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic sample_tick,
  input dccr_fmt_t interface_format_sel,
  input dccr_frame_t frame_cfg,
  input logic power_save_policy,
  input dccr_pair_ctl_t pair_ctl,
  input logic [NCH-1:0] output_invert,
  input logic [NCH*8-1:0] atten_level,
  input logic [NCH-1:0] ramp_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [3:0] dis;
  logic [3:0] psm;
  assign dis = pair_ctl.data_disconnect;
  assign psm = {4{power_save_policy}};
  // ----
  // port relations
  // ----
  policy_wr_a: assert property (reg_wr && reg_addr == 7'h41 |=>
    power_save_policy == $past(reg_wdata[7])) else $error("policy");
  rj16_dec_a: assert property (interface_format_sel == 4'h3 |->
    frame_cfg.rj_mode && frame_cfg.rj_16bit) else $error("rj16");
  dis_wr_a: assert property (reg_wr && reg_addr == 7'h42 |=>
    dis == $past(reg_wdata[7:4])) else $error("disable");
  cm_hold_a: assert property (
    pair_ctl.hold_common_mode == (dis & psm)) else $error("hold");
  gnd_pd_a: assert property (
    pair_ctl.power_down == (dis & ~psm)) else $error("power down");
  inv_wr_a: assert property (reg_wr && reg_addr == 7'h43 |=>
    output_invert == $past(reg_wdata)) else $error("invert");
  ramp_step_a: assert property ($changed(atten_level[7:0]) &&
    !dis[0] |-> $past(sample_tick)) else $error("step");
  mute_ramp_a: assert property (reg_wr && reg_addr == 7'h44 &&
    reg_wdata[0] && atten_level[7:0] != 8'h00 |=> ramp_busy[0])
    else $error("mute");
  cover property (reg_wr && reg_addr == 7'h44 && reg_wdata[0]);
  cover property ($fell(ramp_busy[0]));
  cover property (|dis && power_save_policy);
endmodule // dccr_regs_asserts

bind dccr_regs dccr_regs_asserts #(.NCH(NCH)) i_chk (.*);

// >>> tb/dccr_host.sv
`timescale 1ns/100ps
module dccr_host (
  input wire logic sys_clk,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic sample_tick
);
  logic [1:0] div_q = 2'h0;
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // ----
  // short sample period keeps full ramps near 8k clocks
  // ----
  always @(posedge sys_clk) div_q <= div_q + 2'h1;
  assign sample_tick = div_q == 2'h3;
  // call just after a rising edge; idle address and data are scrambled
  task automatic xfer(input logic w, input logic [6:0] a,
    input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= (a == 7'h41) ? (d & 8'h8f) : d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge sys_clk);
  endtask
endmodule // dccr_host

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
  import dccr_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, output_invert, ramp_busy, d, e;
  logic reg_wr, reg_rd, sample_tick, power_save_policy;
  logic rd_p = 1'b0;
  dccr_fmt_t interface_format_sel;
  dccr_frame_t frame_cfg;
  dccr_pair_ctl_t pair_ctl;
  logic [63:0] atten_level;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  initial forever #2 sys_clk = ~sys_clk;
  dccr_host i_host (.*);
  dccr_regs i_dut (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    i_host.xfer(1'b0, a, 8'h00);
  endtask
  // ----
  // read data is checked mid-cycle, where it is settled and valid
  // ----
  always @(negedge sys_clk) begin
    cyc++;
    if (rd_p) chk(reg_rdata, exp_q.pop_front());
    rd_p <= reg_rd;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic ramp(input logic [7:0] lvl, input int steps);
    int n;
    n = 0;
    while (atten_level[7:0] !== lvl && n < 9000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(atten_level[7:0], lvl);
    chk({7'h0, n >= (steps - 1) * 32 && n <= steps * 32}, 8'h01);
  endtask
  initial begin
    void'($urandom(32'h4777));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 5; i++) rd(7'h41 + 7'(i), 8'h00);
    rd(7'h48, 8'hff);
    repeat (4) begin
      d = 8'($urandom);
      i_host.xfer(1'b1, 7'h43, d);
      chk(output_invert, d);
      rd(7'h43, d);
    end
    for (int f = 0; f < 10; f++) begin
      d = {1'($urandom), 3'h0, 4'(f)};
      e = 8'($urandom);
      i_host.xfer(1'b1, 7'h41, d);
      i_host.xfer(1'b1, 7'h42, e);
      chk({4'h0, interface_format_sel}, d & 8'h0f);
      chk({1'b0, frame_cfg}, {1'b0, f == 0 || f == 4 || f == 6 || f == 8,
        f == 2 || f == 3, f == 3, f == 4 || f == 5, f > 5, f > 7, 1'b0});
      chk({7'h0, power_save_policy}, {7'h0, d[7]});
      chk({pair_ctl.hold_common_mode, pair_ctl.drive_analog_ground},
        {e[7:4] & {4{d[7]}}, e[7:4] & ~{4{d[7]}}});
      chk({pair_ctl.power_down, pair_ctl.rolloff_slow},
        {e[7:4] & ~{4{d[7]}}, e[3:0]});
      chk({pair_ctl.data_disconnect, pair_ctl.path_clear}, {2{e[7:4]}});
      rd(7'h42, e);
    end
    i_host.xfer(1'b1, 7'h42, 8'h80);
    i_host.xfer(1'b1, 7'h44, 8'h41);
    @(negedge sys_clk);
    chk(atten_level[55:48], 8'h00);
    chk({7'h0, ramp_busy[0]}, 8'h01);
    ramp(8'h00, 255);
    i_host.xfer(1'b1, 7'h48, 8'h80);
    chk(atten_level[7:0], 8'h00);
    i_host.xfer(1'b1, 7'h44, 8'h00);
    ramp(8'h80, 128);
    rd(7'h48, 8'h80);
    end_sim();
  end
endmodule // tb
